// ### hdl/adcc_params.svh
// Purpose: offsets, field positions, reset values and counts of the block
// Assumes: 8-bit registers on a small indexed port
// Notes: included by the top module and by the testbench
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

// register offsets
`define ADCC_OFS_RES_LOW 3'h0
`define ADCC_OFS_RES_HIGH 3'h1
`define ADCC_OFS_CTRL0 3'h2
`define ADCC_OFS_CTRL1 3'h3
`define ADCC_OFS_CTRL2 3'h4
`define ADCC_OFS_PINSEL_LOW 3'h5
`define ADCC_OFS_PINSEL_HIGH 3'h6

// control register zero fields
`define ADCC_C0_START 7
`define ADCC_C0_BUSY 6
`define ADCC_C0_EN 5
`define ADCC_C0_JUST 4
// control register one fields
`define ADCC_C1_SRC_HI 7
`define ADCC_C1_SRC_LO 4
`define ADCC_C1_DIV_HI 2
// control register two fields
`define ADCC_C2_PGA_EN 7
`define ADCC_C2_PGA_IN 4
`define ADCC_C2_REF_HI 3
`define ADCC_C2_REF_LO 2
`define ADCC_C2_GAIN_HI 1

// writable masks, reserved bits read zero
`define ADCC_C0_WMASK 8'hbf
`define ADCC_C1_WMASK 8'hf7
`define ADCC_C2_WMASK 8'h9f
`define ADCC_PIN_WMASK 8'h0f

// reset values
`define ADCC_RST_REG 8'h00
`define ADCC_RST_RES 12'h000

// conversion length in converter clocks
`define ADCC_CONV_CLOCKS 16

`endif

// ### hdl/adcc_pkg.sv
// Purpose: types shared by the converter control block
// Assumes: constants live in adcc_params.svh
// Notes: state codes are gray along idle, armed, convert
package adcc_pkg;

	// sequencer states
	typedef enum logic [1:0] {
		ADCC_IDLE = 2'b00,
		ADCC_ARMED = 2'b01,
		ADCC_CONV = 2'b11
	} adcc_state_e;

	// what drives the converter input
	typedef enum logic [2:0] {
		ADCC_SRC_EXT = 3'h0,
		ADCC_SRC_VDD = 3'h1,
		ADCC_SRC_VDD_HALF = 3'h2,
		ADCC_SRC_VDD_QUARTER = 3'h3,
		ADCC_SRC_VR = 3'h4,
		ADCC_SRC_VR_HALF = 3'h5,
		ADCC_SRC_VR_QUARTER = 3'h6,
		ADCC_SRC_GROUND = 3'h7
	} adcc_src_e;

	// converter reference choice
	typedef enum logic [1:0] {
		ADCC_REF_VDD = 2'h0,
		ADCC_REF_PIN = 2'h1,
		ADCC_REF_VR = 2'h2
	} adcc_ref_e;

endpackage

// ### hdl/adcc_top.sv
// Purpose: control and result registers of a 12-bit SAR converter
// Assumes: analog core, input mux and amplifier sit outside this block
// Notes: core_result is settled on the digital clock when core runs
`timescale 1ns/100ps
`include "adcc_params.svh"

module adcc_top
	import adcc_pkg::*;
#(
	parameter int CHANNELS = 8,
	parameter int CONV_CLOCKS = `ADCC_CONV_CLOCKS
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// analog core
	input wire logic [11:0] core_result,
	output logic core_power,
	output logic core_reset,
	output logic core_run,
	output logic core_tick,
	output logic core_irq_req,
	// input and reference routing
	output logic [2:0] mux_source,
	output logic mux_ext_connect,
	output logic [2:0] mux_ext_channel,
	output logic [1:0] ref_select,
	output logic pga_enable,
	output logic pga_in_bandgap,
	output logic pga_in_pin_connect,
	output logic [1:0] pga_gain,
	// shared pins
	output logic [7:0] pin_analog,
	output logic [7:0] pin_pullup_off
);

	// only the documented variants are served, refused at elaboration
	if (CHANNELS != 4 && CHANNELS != 8) begin : g_chk_channels
		$error("CHANNELS must be 4 or 8");
	end
	if (CONV_CLOCKS < 2 || CONV_CLOCKS > 255) begin : g_chk_length
		$error("CONV_CLOCKS must be 2 to 255");
	end

	logic [7:0] ctrl0_q;
	logic [7:0] ctrl1_q;
	logic [7:0] ctrl2_q;
	logic [7:0] pinsel_lo_q;
	logic [7:0] pinsel_hi_q;
	logic [11:0] result_q;
	adcc_state_e state_q;
	logic [6:0] pre_cnt_q;
	logic [7:0] conv_cnt_q;
	logic tick;
	logic done;
	logic [6:0] div_mask;
	logic start_bit;
	logic en_bit;
	logic just_bit;
	logic busy;
	logic [7:0] res_low;
	logic [7:0] res_high;
	logic [3:0] src_code;
	adcc_src_e src_d;
	logic ext_ok;

	assign start_bit = ctrl0_q[`ADCC_C0_START];
	assign en_bit = ctrl0_q[`ADCC_C0_EN];
	assign just_bit = ctrl0_q[`ADCC_C0_JUST];
	assign busy = (state_q == ADCC_CONV);
	assign src_code = ctrl1_q[`ADCC_C1_SRC_HI:`ADCC_C1_SRC_LO];

	// control registers, start bit kept as written
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ctrl0_q <= `ADCC_RST_REG;
			ctrl1_q <= `ADCC_RST_REG;
			ctrl2_q <= `ADCC_RST_REG;
			pinsel_lo_q <= `ADCC_RST_REG;
			pinsel_hi_q <= `ADCC_RST_REG;
		end else if (reg_wr) begin
			case (reg_addr)
				`ADCC_OFS_CTRL0: ctrl0_q <= reg_wdata & `ADCC_C0_WMASK;
				`ADCC_OFS_CTRL1: ctrl1_q <= reg_wdata & `ADCC_C1_WMASK;
				`ADCC_OFS_CTRL2: ctrl2_q <= reg_wdata & `ADCC_C2_WMASK;
				`ADCC_OFS_PINSEL_LOW: pinsel_lo_q <= reg_wdata & `ADCC_PIN_WMASK;
				`ADCC_OFS_PINSEL_HIGH: pinsel_hi_q <= reg_wdata & `ADCC_PIN_WMASK;
				default: ;
			endcase
		end
	end

	// start sequencer: rise arms and resets, fall launches
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_q <= ADCC_IDLE;
		end else begin
			case (state_q)
				ADCC_IDLE: begin
					if (start_bit)
						state_q <= ADCC_ARMED;
				end
				ADCC_ARMED: begin
					// disabled converter never starts
					if (!start_bit)
						state_q <= en_bit ? ADCC_CONV : ADCC_IDLE;
				end
				ADCC_CONV: begin
					if (start_bit)
						state_q <= ADCC_ARMED;
					else if (!en_bit || done)
						state_q <= ADCC_IDLE;
				end
				default: state_q <= ADCC_IDLE;
			endcase
		end
	end

	// converter clock prescaler, restarted with each conversion
	assign div_mask = 7'h7f >> (3'h7 - ctrl1_q[`ADCC_C1_DIV_HI:0]);
	assign tick = busy && (pre_cnt_q == div_mask);
	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			pre_cnt_q <= 7'h00;
		else if (!busy || tick)
			pre_cnt_q <= 7'h00;
		else
			pre_cnt_q <= pre_cnt_q + 7'h01;
	end

	// conversion length in converter clocks
	assign done = tick && (conv_cnt_q == 8'(CONV_CLOCKS - 1));
	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			conv_cnt_q <= 8'h00;
		else if (!busy)
			conv_cnt_q <= 8'h00;
		else if (tick)
			conv_cnt_q <= conv_cnt_q + 8'h01;
	end

	// result taken as busy drops; an abort by disable keeps old data
	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			result_q <= `ADCC_RST_RES;
		else if (done && en_bit && !start_bit)
			result_q <= core_result;
	end

	// formatting happens at read time so justify needs no new conversion
	always_comb begin
		if (just_bit) begin
			res_high = {4'h0, result_q[11:8]};
			res_low = result_q[7:0];
		end else begin
			res_high = result_q[11:4];
			res_low = {result_q[3:0], 4'h0};
		end
	end

	// read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`ADCC_OFS_RES_LOW: reg_rdata <= res_low;
				`ADCC_OFS_RES_HIGH: reg_rdata <= res_high;
				`ADCC_OFS_CTRL0: begin
					reg_rdata <= ctrl0_q;
					reg_rdata[`ADCC_C0_BUSY] <= busy;
				end
				`ADCC_OFS_CTRL1: reg_rdata <= ctrl1_q;
				`ADCC_OFS_CTRL2: reg_rdata <= ctrl2_q;
				`ADCC_OFS_PINSEL_LOW: reg_rdata <= pinsel_lo_q;
				`ADCC_OFS_PINSEL_HIGH: reg_rdata <= pinsel_hi_q;
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// core handshake outputs, registered for clean pins
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			core_power <= 1'b0;
			core_reset <= 1'b1;
			core_run <= 1'b0;
			core_tick <= 1'b0;
			core_irq_req <= 1'b0;
		end else begin
			core_power <= en_bit;
			core_reset <= (state_q != ADCC_CONV);
			core_run <= busy;
			core_tick <= tick;
			core_irq_req <= done && en_bit && !start_bit;
		end
	end

	// input source decode; internal codes always override the pin
	always_comb begin
		case (src_code)
			4'h1: src_d = ADCC_SRC_VDD;
			4'h2: src_d = ADCC_SRC_VDD_HALF;
			4'h3: src_d = ADCC_SRC_VDD_QUARTER;
			4'h5: src_d = ADCC_SRC_VR;
			4'h6: src_d = ADCC_SRC_VR_HALF;
			4'h7: src_d = ADCC_SRC_VR_QUARTER;
			4'h8, 4'h9, 4'ha, 4'hb: src_d = ADCC_SRC_GROUND;
			default: src_d = ADCC_SRC_EXT;
		endcase
	end

	// codes past the last pin leave the input floating
	assign ext_ok = (32'(ctrl0_q[3:0]) < CHANNELS);

	// routing outputs
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			mux_source <= 3'h0;
			mux_ext_connect <= 1'b0;
			mux_ext_channel <= 3'h0;
			ref_select <= 2'h0;
			pga_enable <= 1'b0;
			pga_in_bandgap <= 1'b0;
			pga_in_pin_connect <= 1'b0;
			pga_gain <= 2'h0;
		end else begin
			mux_source <= src_d;
			mux_ext_connect <= (src_d == ADCC_SRC_EXT) && ext_ok;
			mux_ext_channel <= ctrl0_q[2:0];
			// pin reference only on the one code that names it alone
			if (ctrl2_q[`ADCC_C2_REF_HI])
				ref_select <= ADCC_REF_VR;
			else if (ctrl2_q[`ADCC_C2_REF_LO])
				ref_select <= ADCC_REF_PIN;
			else
				ref_select <= ADCC_REF_VDD;
			pga_enable <= ctrl2_q[`ADCC_C2_PGA_EN];
			pga_in_bandgap <= ctrl2_q[`ADCC_C2_PGA_IN];
			pga_in_pin_connect <= !ctrl2_q[`ADCC_C2_PGA_IN];
			pga_gain <= ctrl2_q[`ADCC_C2_GAIN_HI:0];
		end
	end

	// shared pins; pins beyond the variant never go analog
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			pin_analog <= 8'h00;
			pin_pullup_off <= 8'h00;
		end else begin
			pin_analog <= {pinsel_hi_q[3:0], pinsel_lo_q[3:0]} &
				((CHANNELS == 8) ? 8'hff : 8'h0f);
			pin_pullup_off <= {pinsel_hi_q[3:0], pinsel_lo_q[3:0]} &
				((CHANNELS == 8) ? 8'hff : 8'h0f);
		end
	end

	// helper: last read was low byte with justify clear
	logic rd_low_j0_q;
	always_ff @(posedge clk_sys) begin
		if (!rst_b)
			rd_low_j0_q <= 1'b0;
		else
			rd_low_j0_q <= reg_rd && !just_bit &&
				(reg_addr == `ADCC_OFS_RES_LOW);
	end

	property p_launch;
		@(posedge clk_sys) disable iff (!rst_b)
		(state_q == ADCC_ARMED && !start_bit && en_bit) |=> busy;
	endproperty
	a_launch: assert property (p_launch) else $error("no launch");

	property p_rise_clears;
		@(posedge clk_sys) disable iff (!rst_b)
		$rose(start_bit) |-> ##1 (!busy && state_q == ADCC_ARMED);
	endproperty
	a_rise_clears: assert property (p_rise_clears) else $error("busy kept");

	property p_off_idle;
		@(posedge clk_sys) disable iff (!rst_b)
		(!en_bit && !start_bit) |=> !busy;
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("busy while off");

	property p_hold;
		@(posedge clk_sys) disable iff (!rst_b)
		!en_bit |=> $stable(result_q);
	endproperty
	a_hold: assert property (p_hold) else $error("result moved");

	property p_done;
		@(posedge clk_sys) disable iff (!rst_b)
		core_irq_req |-> (!busy && $past(busy) &&
			result_q == $past(core_result));
	endproperty
	a_done: assert property (p_done) else $error("bad completion");

	property p_low_zero;
		@(posedge clk_sys) disable iff (!rst_b)
		rd_low_j0_q |-> (reg_rdata[3:0] == 4'h0);
	endproperty
	a_low_zero: assert property (p_low_zero) else $error("nibble set");

	property p_internal_wins;
		@(posedge clk_sys) disable iff (!rst_b)
		(src_d != ADCC_SRC_EXT) |=> !mux_ext_connect;
	endproperty
	a_internal_wins: assert property (p_internal_wins) else $error("pin on");

	property p_ground;
		@(posedge clk_sys) disable iff (!rst_b)
		(src_code[3:2] == 2'b10) |=> (mux_source == ADCC_SRC_GROUND);
	endproperty
	a_ground: assert property (p_ground) else $error("not grounded");

	property p_div1;
		@(posedge clk_sys) disable iff (!rst_b)
		(busy && ctrl1_q[2:0] == 3'h1 && tick) |=> !tick;
	endproperty
	a_div1: assert property (p_div1) else $error("divide by 2 broken");

	property p_busy_read;
		@(posedge clk_sys) disable iff (!rst_b)
		(reg_rd && reg_addr == `ADCC_OFS_CTRL0) |=>
			(reg_rdata[`ADCC_C0_BUSY] == $past(busy));
	endproperty
	a_busy_read: assert property (p_busy_read) else $error("busy bit");

endmodule

// ### tb/adcc_core_model.sv
// Purpose: behavioural analog core that answers with a bench-set code
// Assumes: the block samples core_result only at conversion end
// Notes: outside a powered run the output wanders every cycle
`timescale 1ns/100ps

module adcc_core_model (
	// clock
	input wire logic clk_sys,
	// block side
	input wire logic core_power,
	input wire logic core_reset,
	output logic [11:0] core_result,
	// bench side
	input wire logic [11:0] sample
);
	logic [11:0] junk_q = 12'h000;

	// stale value inverted so no leftover code can pass as fresh
	always @(posedge clk_sys) begin
		junk_q <= ~core_result;
	end

	// code valid only while powered and out of reset
	assign core_result = (core_power && !core_reset) ? sample : junk_q;
endmodule

// ### tb/adcc_top_tb.sv
// Purpose: self-checking bench of the converter control block
// Assumes: short conversion length and four-channel variant
// Notes: bus tasks resume 1 ns after the edge they end on
`timescale 1ns/100ps
`include "adcc_params.svh"

module adcc_top_tb;
	localparam int CONV = 4;
	localparam logic [2:0] A_LO = `ADCC_OFS_RES_LOW;
	localparam logic [2:0] A_HI = `ADCC_OFS_RES_HIGH;
	localparam logic [2:0] A_C0 = `ADCC_OFS_CTRL0;
	localparam logic [2:0] A_C1 = `ADCC_OFS_CTRL1;
	localparam logic [2:0] A_C2 = `ADCC_OFS_CTRL2;
	logic clk_sys, rst_b, reg_wr, reg_rd, core_power, core_reset;
	logic core_run, core_tick, core_irq_req, mux_ext_connect;
	logic pga_enable, pga_in_bandgap, pga_in_pin_connect;
	logic [2:0] reg_addr, mux_source, mux_ext_channel;
	logic [7:0] reg_wdata, reg_rdata, pin_analog, pin_pullup_off, rd_q;
	logic [11:0] core_result, sample;
	logic [1:0] ref_select, pga_gain;
	int failures = 0;
	int checked = 0;
	int irqs = 0;
	int ticks = 0;
	int cyc = 0;
	int first_t, last_t, n;

	adcc_top #(.CHANNELS(4), .CONV_CLOCKS(CONV)) u_dut (
		.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .core_result(core_result),
		.core_power(core_power), .core_reset(core_reset),
		.core_run(core_run), .core_tick(core_tick),
		.core_irq_req(core_irq_req), .mux_source(mux_source),
		.mux_ext_connect(mux_ext_connect),
		.mux_ext_channel(mux_ext_channel), .ref_select(ref_select),
		.pga_enable(pga_enable), .pga_in_bandgap(pga_in_bandgap),
		.pga_in_pin_connect(pga_in_pin_connect), .pga_gain(pga_gain),
		.pin_analog(pin_analog), .pin_pullup_off(pin_pullup_off));

	adcc_core_model u_core (.clk_sys(clk_sys), .core_power(core_power),
		.core_reset(core_reset), .core_result(core_result),
		.sample(sample));

	// 250 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// count converter ticks and completion pulses
	always @(posedge clk_sys) begin
		cyc++;
		if (core_tick === 1'b1) begin
			if (ticks == 0) first_t = cyc;
			last_t = cyc;
			ticks++;
		end
		if (core_irq_req === 1'b1) irqs++;
	end

	// compare and count
	task automatic chk(input logic [11:0] seen, exp, input string what);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h want %h", $time, what,
				seen, exp);
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		rd_q = reg_rdata;
	endtask

	// bounded wait for a completion count
	task automatic wait_irq(input int want, input int lim);
		for (int k = 0; k < lim && irqs < want; k++) @(posedge clk_sys);
		#1;
	endtask

	// divider, start high, start low with enable
	task automatic conv(input logic [2:0] div, input logic [11:0] s);
		sample = s;
		wr(A_C1, {5'h00, div});
		ticks = 0;
		wr(A_C0, 8'ha0);
		wr(A_C0, 8'h20);
	endtask

	task automatic t_reset();
		for (int a = 0; a < 8; a++) begin
			rd(a[2:0]);
			chk(rd_q, 8'h00, "reset read");
		end
		chk(core_reset, 1'b1, "core held");
		chk(ref_select, 2'h0, "ref supply");
		$display("test reset done");
	endtask

	task automatic t_route();
		int e;
		wr(A_C0, 8'h03);
		for (int c = 0; c < 16; c++) begin
			e = (c inside {[1:3]}) ? c : (c inside {[5:7]}) ? c - 1 :
				(c inside {[8:11]}) ? 7 : 0;
			wr(A_C1, {c[3:0], 4'h0});
			@(posedge clk_sys);
			#1;
			chk(mux_source, 12'(e), "source");
			chk(mux_ext_connect, e == 0, "pin");
		end
		wr(A_C1, 8'h00);
		wr(A_C0, 8'h04);
		@(posedge clk_sys);
		#1;
		chk(mux_ext_connect, 1'b0, "no pin 4");
		chk(mux_ext_channel, 3'h4, "channel");
		$display("test routing done");
	endtask

	task automatic t_ref();
		wr(A_C2, 8'hff);
		@(posedge clk_sys);
		#1;
		chk(ref_select, 2'h2, "ref");
		chk(pga_in_pin_connect, 1'b0, "amp pin");
		chk(pga_in_bandgap, 1'b1, "bandgap");
		chk({pga_enable, pga_gain}, 3'h7, "amp");
		rd(A_C2);
		chk(rd_q, 8'h9f, "ctrl2 mask");
		wr(A_C2, 8'h04);
		@(posedge clk_sys);
		#1;
		chk(ref_select, 2'h1, "ref pin");
		chk(pga_in_pin_connect, 1'b1, "amp pin on");
		$display("test reference done");
	endtask

	task automatic t_div();
		for (int d = 0; d < 8; d++) begin
			n = irqs;
			conv(d[2:0], 12'ha50 | 12'(d));
			rd(A_C0);
			if (d > 2) chk(rd_q[6], 1'b1, "busy");
			if (d > 2) chk(core_run, 1'b1, "run");
			wait_irq(n + 1, 1000);
			chk(12'(irqs), 12'(n + 1), "done");
			chk(12'(ticks), 12'(CONV), "ticks");
			chk(12'(last_t - first_t), 12'((CONV - 1) << d), "span");
			rd(A_HI);
			chk(rd_q, 8'ha5, "high");
			rd(A_LO);
			chk(rd_q, {d[3:0], 4'h0}, "low");
		end
		wr(A_C0, 8'h30);
		rd(A_HI);
		chk(rd_q, 8'h0a, "right high");
		rd(A_LO);
		chk(rd_q, 8'h57, "right low");
		rd(A_C0);
		chk(rd_q, 8'h30, "ctrl0 idle");
		chk(12'(irqs), 12'(n + 1), "no rerun");
		$display("test divider done");
	endtask

	task automatic t_en();
		n = irqs;
		wr(A_C0, 8'h80);
		wr(A_C0, 8'h00);
		wait_irq(n + 1, 40);
		chk(12'(irqs), 12'(n), "off start");
		chk(core_power, 1'b0, "power");
		conv(3'h7, 12'h3c3);
		wr(A_C0, 8'h00);
		rd(A_C0);
		chk(rd_q[6], 1'b0, "abort");
		chk(core_run, 1'b0, "run off");
		wait_irq(n + 1, 600);
		chk(12'(irqs), 12'(n), "aborted");
		rd(A_HI);
		chk(rd_q, 8'ha5, "kept");
		$display("test enable done");
	endtask

	task automatic t_restart();
		n = irqs;
		conv(3'h7, 12'h5e1);
		wr(A_C0, 8'ha0);
		rd(A_C0);
		chk(rd_q[6], 1'b0, "reset busy");
		chk(core_reset, 1'b1, "core reset");
		wr(A_C0, 8'h20);
		wait_irq(n + 1, 1000);
		chk(12'(irqs), 12'(n + 1), "restart");
		rd(A_LO);
		chk(rd_q, 8'h10, "new low");
		wr(`ADCC_OFS_PINSEL_LOW, 8'hff);
		wr(`ADCC_OFS_PINSEL_HIGH, 8'hff);
		wr(A_HI, 8'hff);
		chk(pin_analog, 8'h0f, "analog");
		chk(pin_pullup_off, 8'h0f, "pullup");
		rd(A_HI);
		chk(rd_q, 8'h5e, "read only");
		$display("test restart done");
	endtask

	task automatic print_verdict();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// watchdog well past the expected run length
	initial begin
		#200000;
		failures++;
		print_verdict();
	end

	// main sequence
	initial begin
		{rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		sample = 12'h000;
		repeat (5) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_reset();
		t_route();
		t_ref();
		t_div();
		t_en();
		t_restart();
		print_verdict();
	end
endmodule
